// [rtl/dud_defines.svh]
// Constants shared by the converter update block and its host end.
// Included by bare name; holds definitions only.
`ifndef DUD_DEFINES_SVH
`define DUD_DEFINES_SVH

// Device register addresses on the link (5 bits).
`define DUD_A_NOP    5'h00
`define DUD_A_INPUT  5'h01
`define DUD_A_GAIN   5'h02
`define DUD_A_OFFS   5'h03
`define DUD_A_CLEAR  5'h04
`define DUD_A_CFG    5'h05
`define DUD_A_KEY    5'h06
`define DUD_A_SETA   5'h07
`define DUD_A_SETB   5'h08
`define DUD_A_CHK    5'h09
`define DUD_A_RES    5'h0a
`define DUD_A_STAT   5'h0b
`define DUD_A_TICKS  5'h0c
`define DUD_A_RBSEL  5'h0d
`define DUD_A_SLOAD  5'h0e
`define DUD_A_OUT    5'h0f
`define DUD_A_WDC    5'h10
`define DUD_A_ANA    5'h11

// Key codes.
`define DUD_KEY_RST1 16'h15fa
`define DUD_KEY_RST2 16'haf51
`define DUD_KEY_CAL  16'hfcba

// Field positions.
`define DUD_CFG_SLEW  4
`define DUD_SETA_HALT 0
`define DUD_SETB_GLOB 0
`define DUD_CHK_INV   0
`define DUD_CHK_LATCH 1
`define DUD_CHK_CRC   2
`define DUD_CHK_TICK  3
`define DUD_WDC_FALL  0
`define DUD_WDC_RST   1
`define DUD_R_RESET   0
`define DUD_R_WDOG    1
`define DUD_R_LATCH   2
`define DUD_R_INV     3
`define DUD_R_CRC     4
`define DUD_R_INVAL   5
`define DUD_R_PEND    6
`define DUD_R_SLEW    7
`define DUD_R_HALT    8

// Reset values.
`define DUD_GAIN_RST 16'hffff
`define DUD_OFFS_RST 16'h8000
`define DUD_CHK_RST  16'h000d
`define DUD_SETA_RST 16'h0001

// Fixed words, steps and counts.
`define DUD_HALT_WORD  24'h07dead
`define DUD_SLEW_STEP  16'h0100
`define DUD_CAL_WORDS  4
`define DUD_SETTLE     2'h3
`define DUD_TICK_DIV   10000
`define DUD_CLK_MHZ    250
`define DUD_CAL_WAIT_US 500
`define DUD_CAL_WAIT   (`DUD_CAL_WAIT_US * `DUD_CLK_MHZ)

// Host APB register offsets.
`define DUD_H_CMD  12'h000
`define DUD_H_STAT 12'h004
`define DUD_H_RDBK 12'h008
`define DUD_H_CTRL 12'h00c

`endif

// [rtl/dud_pkg.sv]
// Types for the converter update block and its host end.
// Assumes nothing of its surroundings.
package dud_pkg;

  typedef struct packed {
    logic [15:0] code, gain, offs, clr, cfg, seta, setb, chk, wdc, rbsel;
    logic [15:0] outv, target, dac, dac_inv, ticks, res;
    logic [13:0] pre;
    logic [3:0]  calcnt, ana;
    logic [7:0]  crc;
    logic [23:0] rdw;
    logic        pend, fallback, armed, strobe, key1;
    logic [1:0]  settle;
    logic [2:0]  ls;
    logic [1:0]  hs;
    logic [15:0] lat1, lat2;
    logic [3:0]  ana1, ana2;
  } dud_dev_t;

  typedef enum logic [1:0] {
    DUD_IDLE = 2'b00,
    DUD_KEY2 = 2'b01,
    DUD_WAIT = 2'b10
  } dud_hfsm_t;

  typedef struct packed {
    dud_hfsm_t   fsm;
    logic        wr_valid, lsn, need_code, refused, pready, pslverr;
    logic [4:0]  wr_addr;
    logic [15:0] wr_data;
    logic [31:0] prdata, waitcnt;
  } dud_host_t;

endpackage

// [rtl/dud_if.sv]
// Link between the host end and the converter update block.
// Both ends run on pclk with reset presetn.
`timescale 1ns/1ps
`default_nettype none
interface dud_if (
  input wire logic pclk,    // Common clock.
  input wire logic presetn  // Asynchronous reset, active low.
);
  logic        wr_valid;      // One-cycle register write.
  logic [4:0]  wr_addr;       // Register address.
  logic [15:0] wr_data;       // Write data.
  logic [23:0] rd_word;       // Readback word.
  logic        load_strobe_n; // Hardware load pin.

  modport dev (
    input  pclk, presetn, wr_valid, wr_addr, wr_data, load_strobe_n,
    output rd_word
  );
  modport host (
    input  pclk, presetn, rd_word,
    output wr_valid, wr_addr, wr_data, load_strobe_n
  );
endinterface
`default_nettype wire

// [rtl/dud_code_calc.sv]
// Gain and offset arithmetic for the converter code.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module dud_code_calc (
  input  wire logic [15:0] code,  // Input code.
  input  wire logic [15:0] gain,  // Gain trim.
  input  wire logic [15:0] offs,  // Offset trim.
  output logic      [15:0] result // Clamped converter code.
);
  logic [32:0] prod;
  logic [18:0] sum;

  // Code times (gain+1) over 2^16, plus offset, minus 2^15.
  always_comb
  begin
    prod = {17'h0, code} * {16'h0, 17'({1'b0, gain} + 17'h1)};
    sum = {2'h0, prod[32:16]} + {3'h0, offs} - 19'h08000;
    if (sum[18])
      result = 16'h0000;
    else if (sum[17:16] != 2'h0)
      result = 16'hffff;
    else
      result = sum[15:0];
  end
endmodule // dud_code_calc
`default_nettype wire

// [rtl/dud_dev.sv]
// Converter update and data-integrity logic: load control, checks,
// keys, calibration refresh, oscillator monitor and sticky flags.
// Assumes the host keeps the write ordering described below.
//
// How it works
// [R1] Strobe low: write loads output at frame end.
// [R2] Strobe high: code waits for load event.
// [R3] Timeout with fallback enabled loads clear code.
// [R4] Slew enabled: output register shows stepped value.
// [R5] Watchdog flag blocks code writes and loads.
// [R6] After fallback, loads reload clear code until a new code write.
// [R7] Host writes code after range setup.
// [R8] Host writes trims before the code.
// [R9] Global mode: load command ignores address bits.
// [R10] Code and inverse copy checked before strobe.
// [R11] Latch monitor flags mismatch with latch code.
// [R12] Reset needs two key writes in order.
// [R13] Reset from pin, keys or timeout.
// [R14] Reset flag sets on reset, write-1 clears.
// [R15] Refresh on key or range change, CRC checked.
// [R16] Refresh: only readback-select and no-op writes allowed.
// [R17] Host waits 500 us after refresh start.
// [R18] Tick counter counts oscillator divided by 10000.
// [R19] Halted oscillator sends fixed word every frame.
// [R20] Write one reloads flag with present fault.
// [R21] Pending and slew flags clear by themselves.
// [R22] Status holds analog and logic summary bits.
// [R23] Code from gain and offset arithmetic.
// [R24] Failed inverse check blocks strobe, sets flag.
`timescale 1ns/1ps
`default_nettype none
`include "dud_defines.svh"
module dud_dev #(
  parameter int          TICK_DIV = `DUD_TICK_DIV, // Cycles per tick.
  parameter logic [7:0]  CAL_REF  = 8'h00,         // Reference CRC.
  parameter logic [63:0] SHADOW   = 64'h0          // Calibration words.
) (
  dud_if.dev               lnk,        // Link to the host.
  input  wire logic [3:0]  dev_addr,   // Device address straps.
  input  wire logic        wdog_tmo,   // Watchdog timeout pulse.
  input  wire logic        osc_halted, // Oscillator stop detector.
  input  wire logic [15:0] latch_code, // Code seen at the latches.
  input  wire logic [3:0]  ana_fault,  // Analog fault conditions.
  output logic      [15:0] dac_code,   // Checked converter code.
  output logic             dac_strobe, // Converter update pulse.
  output logic      [15:0] out_code    // Momentary output code.
);
  dud_pkg::dud_dev_t s_q, s_d;
  logic [15:0] calc;
  logic [15:0] pres;
  logic [15:0] rd;
  logic [15:0] step;
  logic        w, wd_flag, refresh, load_ev, halted, swrst, cal_go;

  dud_code_calc u_calc (
    .code   (s_q.code),
    .gain   (s_q.gain),
    .offs   (s_q.offs),
    .result (calc)
  );

  function automatic dud_pkg::dud_dev_t dev_init();
    dud_pkg::dud_dev_t v;
    v = '0;
    v.gain = `DUD_GAIN_RST;
    v.offs = `DUD_OFFS_RST;
    v.chk = `DUD_CHK_RST;
    v.seta = `DUD_SETA_RST;
    v.res[`DUD_R_RESET] = 1'b1;
    v.ls = 3'h7;
    return v;
  endfunction

  function automatic logic [7:0] crc8(logic [7:0] c, logic [15:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 15; i >= 0; i--)
      r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? 8'h07 : 8'h00);
    return r;
  endfunction

  assign dac_code = s_q.dac;
  assign dac_strobe = s_q.strobe;
  assign out_code = s_q.outv;
  assign lnk.rd_word = s_q.rdw;

  always_comb
  begin
    s_d = s_q;
    w = lnk.wr_valid;
    wd_flag = s_q.res[`DUD_R_WDOG];
    refresh = s_q.calcnt != 4'h0;
    halted = s_q.hs[1] & s_q.seta[`DUD_SETA_HALT];
    swrst = 1'b0;
    cal_go = 1'b0;
    load_ev = 1'b0;
    pres = '0;
    s_d.strobe = 1'b0;
    // Pin synchronisers.
    s_d.ls = {s_q.ls[1:0], lnk.load_strobe_n};
    s_d.hs = {s_q.hs[0], osc_halted};
    s_d.lat1 = latch_code;
    s_d.lat2 = s_q.lat1;
    s_d.ana1 = ana_fault;
    s_d.ana2 = s_q.ana1;
    // Hardware strobe pulsed low.
    if (s_q.ls[2] && !s_q.ls[1])
      load_ev = 1'b1; // [R2]
    // Strobe held low: a code written last cycle loads now, so the
    // arithmetic sees the new code rather than the one before it.
    if (s_q.pend && !s_q.ls[1])
      load_ev = 1'b1; // [R1]
    if (w)
      s_d.key1 = 1'b0;
    if (w && refresh && lnk.wr_addr != `DUD_A_RBSEL &&
        lnk.wr_addr != `DUD_A_NOP)
      s_d.res[`DUD_R_INVAL] = 1'b1; // [R16]
    else if (w)
    begin
      case (lnk.wr_addr)
        `DUD_A_INPUT:
          if (!wd_flag) // [R5]
          begin
            s_d.code = lnk.wr_data;
            s_d.fallback = 1'b0; // [R6]
            s_d.pend = 1'b1; // [R2]
          end
        `DUD_A_GAIN: s_d.gain = lnk.wr_data;
        `DUD_A_OFFS: s_d.offs = lnk.wr_data;
        `DUD_A_CLEAR: s_d.clr = lnk.wr_data;
        `DUD_A_SETA: s_d.seta = lnk.wr_data;
        `DUD_A_SETB: s_d.setb = lnk.wr_data;
        `DUD_A_CHK: s_d.chk = lnk.wr_data;
        `DUD_A_WDC: s_d.wdc = lnk.wr_data;
        `DUD_A_RBSEL: s_d.rbsel = lnk.wr_data;
        `DUD_A_CFG:
        begin
          s_d.cfg = lnk.wr_data;
          if (lnk.wr_data[3:0] != s_q.cfg[3:0])
            cal_go = 1'b1; // [R15]
        end
        `DUD_A_KEY:
        begin
          if (s_q.key1 && lnk.wr_data == `DUD_KEY_RST2)
            swrst = 1'b1; // [R12]
          s_d.key1 = lnk.wr_data == `DUD_KEY_RST1; // [R12]
          if (lnk.wr_data == `DUD_KEY_CAL)
            cal_go = 1'b1; // [R15]
        end
        `DUD_A_SLOAD:
          if (s_q.setb[`DUD_SETB_GLOB] || lnk.wr_data[3:0] == dev_addr)
            load_ev = 1'b1; // [R9]
        default: ;
      endcase
    end
    // Load: pending code, or the clear code after a fallback.
    if (load_ev && !wd_flag && (s_q.pend || s_q.fallback)) // [R5]
    begin
      s_d.target = s_q.fallback ? s_q.clr : calc; // [R6] [R23]
      s_d.pend = 1'b0;
      s_d.armed = 1'b1;
    end
    // Fault conditions as they stand now, for write-one updates.
    pres[`DUD_R_LATCH] = s_q.chk[`DUD_CHK_LATCH] && s_q.settle == 2'h0 &&
                         s_q.lat2 != s_q.dac; // [R11]
    pres[`DUD_R_HALT] = halted;
    if (w && !refresh && lnk.wr_addr == `DUD_A_RES)
      s_d.res = (s_q.res & ~lnk.wr_data) | (lnk.wr_data & pres); // [R20]
    if (w && !refresh && lnk.wr_addr == `DUD_A_ANA)
      s_d.ana = (s_q.ana & ~lnk.wr_data[3:0]) |
                (lnk.wr_data[3:0] & s_q.ana2); // [R20]
    s_d.ana = s_d.ana | s_q.ana2;
    // Events set flags after any write-one update, so set wins.
    s_d.res[`DUD_R_LATCH] = s_d.res[`DUD_R_LATCH] | pres[`DUD_R_LATCH];
    s_d.res[`DUD_R_HALT] = s_d.res[`DUD_R_HALT] | halted;
    if (wdog_tmo)
    begin
      s_d.res[`DUD_R_WDOG] = 1'b1;
      if (s_q.wdc[`DUD_WDC_FALL])
      begin
        s_d.target = s_q.clr; // [R3]
        s_d.armed = 1'b1;
        s_d.fallback = 1'b1;
        s_d.pend = 1'b0;
      end
      if (s_q.wdc[`DUD_WDC_RST])
        swrst = 1'b1; // [R13]
    end
    // Output stepping toward the target.
    if (!s_q.cfg[`DUD_CFG_SLEW] || s_q.outv == s_d.target)
      s_d.outv = s_d.target;
    else if (s_q.outv < s_d.target)
    begin
      step = s_d.target - s_q.outv;
      s_d.outv = s_q.outv + ((step < `DUD_SLEW_STEP) ? step
                                                     : `DUD_SLEW_STEP); // [R4]
    end
    else
    begin
      step = s_q.outv - s_d.target;
      s_d.outv = s_q.outv - ((step < `DUD_SLEW_STEP) ? step
                                                     : `DUD_SLEW_STEP); // [R4]
    end
    step = '0;
    s_d.res[`DUD_R_SLEW] = s_d.outv != s_d.target; // [R21]
    // Stage code and inverse copy, strobe next cycle if they agree.
    if (s_d.outv != s_q.outv || s_d.armed)
    begin
      s_d.dac = s_d.outv;
      s_d.dac_inv = ~s_d.outv;
      s_d.armed = 1'b1;
    end
    if (s_q.armed)
    begin
      if (!s_q.chk[`DUD_CHK_INV] || s_q.dac == ~s_q.dac_inv) // [R10]
      begin
        s_d.strobe = 1'b1;
        s_d.settle = `DUD_SETTLE;
      end
      else
        s_d.res[`DUD_R_INV] = 1'b1; // [R24]
      s_d.armed = s_d.outv != s_q.outv;
    end
    else if (s_q.settle != 2'h0)
      s_d.settle = s_q.settle - 2'h1;
    // Calibration refresh with CRC over the shadow words.
    if (refresh)
    begin
      s_d.crc = crc8(s_q.crc, SHADOW[16*(s_q.calcnt-4'h1) +: 16]); // [R15]
      s_d.calcnt = s_q.calcnt - 4'h1;
      if (s_q.calcnt == 4'h1 && s_q.chk[`DUD_CHK_CRC] && s_d.crc != CAL_REF)
        s_d.res[`DUD_R_CRC] = 1'b1; // [R15]
    end
    if (cal_go)
    begin
      s_d.calcnt = 4'(`DUD_CAL_WORDS);
      s_d.crc = 8'h00;
    end
    s_d.res[`DUD_R_PEND] = s_d.calcnt != 4'h0; // [R21]
    // Oscillator tick counter.
    if (s_q.chk[`DUD_CHK_TICK])
    begin
      if (s_q.pre == 14'(TICK_DIV - 1))
      begin
        s_d.pre = '0;
        s_d.ticks = s_q.ticks + 16'h1; // [R18]
      end
      else
        s_d.pre = s_q.pre + 14'h1;
    end
    // Readback.
    case (s_q.rbsel[4:0])
      `DUD_A_INPUT: rd = s_q.code;
      `DUD_A_GAIN: rd = s_q.gain;
      `DUD_A_OFFS: rd = s_q.offs;
      `DUD_A_CLEAR: rd = s_q.clr;
      `DUD_A_CFG: rd = s_q.cfg;
      `DUD_A_SETA: rd = s_q.seta;
      `DUD_A_SETB: rd = s_q.setb;
      `DUD_A_CHK: rd = s_q.chk;
      `DUD_A_WDC: rd = s_q.wdc;
      `DUD_A_RES: rd = s_q.res;
      `DUD_A_ANA: rd = {12'h0, s_q.ana};
      `DUD_A_STAT: rd = {13'h0, wd_flag, |s_q.ana, // [R22]
                         |(s_q.res & ~(16'h1 << `DUD_R_SLEW))};
      `DUD_A_TICKS: rd = s_q.ticks;
      `DUD_A_OUT: rd = s_q.outv;
      default: rd = 16'h0000;
    endcase
    s_d.rdw = halted ? `DUD_HALT_WORD : {3'h0, s_q.rbsel[4:0], rd}; // [R19]
    if (swrst)
    begin
      s_d = dev_init(); // [R13] [R14]
      s_d.ls = s_q.ls;
      s_d.hs = s_q.hs;
      s_d.lat2 = s_q.lat2;
      s_d.ana2 = s_q.ana2;
    end
  end

  always_ff @(posedge lnk.pclk or negedge lnk.presetn)
  begin
    if (!lnk.presetn)
      s_q <= dev_init(); // [R14]
    else
      s_q <= s_d;
  end
endmodule // dud_dev
`default_nettype wire

// [rtl/dud_host.sv]
// Host end: takes orders over APB and drives the device link.
// Assumes an APB master on pclk and the device on the link.
`timescale 1ns/1ps
`default_nettype none
`include "dud_defines.svh"
module dud_host #(
  parameter int CAL_WAIT = `DUD_CAL_WAIT // Refresh wait in cycles.
) (
  dud_if.host              lnk,     // Link to the device.
  input  wire logic        psel,    // APB select.
  input  wire logic        penable, // APB enable.
  input  wire logic        pwrite,  // APB direction.
  input  wire logic [11:0] paddr,   // APB address.
  input  wire logic [31:0] pwdata,  // APB write data.
  output logic      [31:0] prdata,  // APB read data.
  output logic             pready,  // APB ready.
  output logic             pslverr  // APB error.
);
  dud_pkg::dud_host_t s_q, s_d;
  logic wr, setup;
  logic [4:0] a;

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign lnk.wr_valid = s_q.wr_valid;
  assign lnk.wr_addr = s_q.wr_addr;
  assign lnk.wr_data = s_q.wr_data;
  assign lnk.load_strobe_n = s_q.lsn;

  always_comb
  begin
    s_d = s_q;
    s_d.wr_valid = 1'b0;
    setup = psel && !penable;
    wr = psel && penable && s_q.pready && pwrite;
    a = pwdata[20:16];
    s_d.pready = setup;
    s_d.pslverr = setup && paddr != `DUD_H_CMD && paddr != `DUD_H_STAT &&
                  paddr != `DUD_H_RDBK && paddr != `DUD_H_CTRL;
    case (paddr)
      `DUD_H_STAT: s_d.prdata = {29'h0, s_q.fsm != dud_pkg::DUD_IDLE,
                                 s_q.need_code, s_q.refused};
      `DUD_H_RDBK: s_d.prdata = {8'h0, lnk.rd_word};
      `DUD_H_CTRL: s_d.prdata = {31'h0, s_q.lsn};
      default: s_d.prdata = 32'h0;
    endcase
    case (s_q.fsm)
      dud_pkg::DUD_KEY2:
      begin
        s_d.wr_valid = 1'b1;
        s_d.wr_data = `DUD_KEY_RST2; // [R12]
        s_d.fsm = dud_pkg::DUD_IDLE;
      end
      dud_pkg::DUD_WAIT:
      begin
        s_d.waitcnt = s_q.waitcnt - 32'h1;
        if (s_q.waitcnt == 32'h1)
          s_d.fsm = dud_pkg::DUD_IDLE; // [R17]
      end
      default: ;
    endcase
    if (wr && paddr == `DUD_H_STAT && pwdata[0])
      s_d.refused = 1'b0;
    if (wr && paddr == `DUD_H_CTRL)
    begin
      s_d.lsn = pwdata[0];
      if (pwdata[1] && s_q.fsm == dud_pkg::DUD_IDLE)
      begin
        s_d.wr_valid = 1'b1;
        s_d.wr_addr = `DUD_A_KEY;
        s_d.wr_data = `DUD_KEY_RST1; // [R12]
        s_d.fsm = dud_pkg::DUD_KEY2;
      end
      else if (pwdata[1])
        s_d.refused = 1'b1;
    end
    if (wr && paddr == `DUD_H_CMD)
    begin
      if (s_q.fsm != dud_pkg::DUD_IDLE ||
          (a == `DUD_A_SLOAD && s_q.need_code)) // [R7] [R8]
        s_d.refused = 1'b1;
      else
      begin
        s_d.wr_valid = 1'b1;
        s_d.wr_addr = a;
        s_d.wr_data = pwdata[15:0];
        if (a == `DUD_A_CFG || a == `DUD_A_GAIN || a == `DUD_A_OFFS)
          s_d.need_code = 1'b1; // [R7] [R8]
        if (a == `DUD_A_INPUT)
          s_d.need_code = 1'b0;
        if (a == `DUD_A_CFG ||
            (a == `DUD_A_KEY && pwdata[15:0] == `DUD_KEY_CAL))
        begin
          s_d.fsm = dud_pkg::DUD_WAIT; // [R17]
          s_d.waitcnt = 32'(CAL_WAIT);
        end
      end
    end
  end

  always_ff @(posedge lnk.pclk or negedge lnk.presetn)
  begin
    if (!lnk.presetn)
    begin
      s_q <= '0;
      s_q.lsn <= 1'b1;
    end
    else
      s_q <= s_d;
  end
endmodule // dud_host
`default_nettype wire

// [dv/dud_link_properties.sv]
// Link checks for the converter update block and its host end.
// Assumes both ends share pclk and presetn; sees link signals only.
`timescale 1ns/1ps
`default_nettype none
`include "dud_defines.svh"
module dud_link_properties #(
  parameter int CAL_WAIT = 20 // Refresh wait in cycles.
) (
  input wire logic        pclk,         // Clock.
  input wire logic        presetn,      // Reset, active low.
  input wire logic        wr_valid,     // Link write.
  input wire logic [4:0]  wr_addr,      // Link address.
  input wire logic [15:0] wr_data,      // Link data.
  input wire logic [23:0] rd_word,      // Readback word.
  input wire logic        load_strobe_n // Load pin.
);
  localparam int QUIET = CAL_WAIT - 2;
  logic [31:0] quiet_q;
  logic        need_q;
  logic        key1, key2, cal, trim, code;
  assign key1 = wr_valid && wr_addr == `DUD_A_KEY;
  assign key2 = key1 && wr_data == `DUD_KEY_RST2;
  assign cal  = wr_valid && (wr_addr == `DUD_A_CFG ||
                (key1 && wr_data == `DUD_KEY_CAL));
  assign trim = wr_valid && (wr_addr == `DUD_A_CFG ||
                wr_addr == `DUD_A_GAIN || wr_addr == `DUD_A_OFFS);
  assign code = wr_valid && wr_addr == `DUD_A_INPUT;
  // Counts cycles since the last refresh start, saturating at QUIET.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      quiet_q <= '0;
      need_q  <= 1'b0;
    end
    else
    begin
      if (cal)
        quiet_q <= 32'h1;
      else if (quiet_q != 0 && quiet_q < QUIET)
        quiet_q <= quiet_q + 32'h1;
      if (trim)
        need_q <= 1'b1;
      else if (code)
        need_q <= 1'b0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence key1_s;
    key1 && wr_data == `DUD_KEY_RST1;
  endsequence
  sequence key2_s;
    key2;
  endsequence
  wr_pulse_a: assert property (wr_valid && !key1 |=> !wr_valid)
    else $error("link write held longer than one cycle");
  key_follow_a: assert property (key1_s |=> key2_s)
    else $error("first reset key not followed by second");
  key_order_a: assert property (key2_s |-> $past(key1, 1))
    else $error("second reset key without first");
  cal_quiet_a: assert property (wr_valid && quiet_q != 0 |->
    quiet_q >= QUIET)
    else $error("link write during refresh wait");
  sload_gate_a: assert property (wr_valid &&
    wr_addr == `DUD_A_SLOAD |-> !need_q)
    else $error("soft load sent before new input code");
  strobe_reset_a: assert property ($rose(presetn) |-> load_strobe_n)
    else $error("load pin low after reset");
  halt_word_a: assert property (rd_word[23:21] == 3'b000)
    else $error("readback word top bits set");
  addr_range_a: assert property (wr_valid |->
    wr_addr <= `DUD_A_ANA)
    else $error("link write to unmapped register");
endmodule // dud_link_properties
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench joining host end and device over the link.
// Assumes APB on pclk at 250 MHz; results checked from queues.
`timescale 1ns/1ps
`default_nettype none
`include "dud_defines.svh"
`define CHK(a, b) \
  begin \
    checks++; \
    if ((a) !== (b)) \
    begin \
      failures++; \
      $display("unexpected at %0t: got %h want %h", $time, a, b); \
    end \
  end
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, t1, er, em;
  logic [3:0]  dev_addr, ana_fault;
  logic        wdog_tmo, osc_halted, latch_flip, err, dac_strobe;
  logic [15:0] latch_code, dac_code, out_code, k, ed;
  int          failures, checks, cyc;
  logic [15:0] exp_dac[$];
  logic [31:0] exp_rd[$], exp_mk[$];
  dud_if dud_if_i (.pclk(pclk), .presetn(presetn));
  dud_dev #(.TICK_DIV(8)) dud_dev_i (.lnk(dud_if_i.dev),
    .dev_addr(dev_addr), .wdog_tmo(wdog_tmo), .osc_halted(osc_halted),
    .latch_code(latch_code), .ana_fault(ana_fault), .dac_code(dac_code),
    .dac_strobe(dac_strobe), .out_code(out_code));
  dud_host #(.CAL_WAIT(20)) dud_host_i (.lnk(dud_if_i.host),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  dud_link_properties #(.CAL_WAIT(20)) dud_link_properties_i (
    .pclk(pclk), .presetn(presetn), .wr_valid(dud_if_i.wr_valid),
    .wr_addr(dud_if_i.wr_addr), .wr_data(dud_if_i.wr_data),
    .rd_word(dud_if_i.rd_word), .load_strobe_n(dud_if_i.load_strobe_n));
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    latch_code <= dac_code ^ {15'h0, latch_flip};
    if (dac_strobe === 1'b1)
    begin
      if (exp_dac.size() == 0)
        `CHK(dac_strobe, 1'b0)
      else
      begin
        ed = exp_dac.pop_front();
        `CHK(dac_code, ed)
      end
    end
    if (psel && penable && pready === 1'b1 && !pwrite && exp_rd.size())
    begin
      er = exp_rd.pop_front();
      em = exp_mk.pop_front();
      `CHK(prdata & em, er & em)
    end
    if (cyc == 30000)
    begin
      failures++;
      report_and_stop();
    end
  end
  function automatic logic [15:0] calc(logic [15:0] d, g, o);
    longint v;
    v = (longint'(d) * (longint'(g) + 1)) / 65536 + o - 32768;
    return v[15:0];
  endfunction
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [4:0] a, input logic [15:0] d);
    apb(1'b1, `DUD_H_CMD, {11'h0, a, d});
    do apb(1'b0, `DUD_H_STAT, 32'h0); while (rd[2] !== 1'b0);
    repeat (4) @(posedge pclk);
  endtask
  task automatic hrd(input logic [11:0] a, input logic [31:0] e, m);
    exp_rd.push_back(e);
    exp_mk.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic rdev(input logic [4:0] a, input logic [15:0] e, m);
    cmd(`DUD_A_RBSEL, {11'h0, a});
    hrd(`DUD_H_RDBK, {11'h0, a, e}, {11'h0, 5'h1f, m});
  endtask
  task automatic pulse_wdog();
    @(posedge pclk);
    wdog_tmo <= 1'b1;
    @(posedge pclk);
    wdog_tmo <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  initial
  begin
    {psel, penable, pwrite, wdog_tmo, osc_halted, latch_flip} = '0;
    {paddr, pwdata, ana_fault, latch_code} = '0;
    failures = 0;
    checks = 0;
    cyc = 0;
    void'($urandom(67));
    dev_addr = 4'($urandom());
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdev(`DUD_A_RES, 16'h0001, 16'h003f);
    rdev(`DUD_A_GAIN, `DUD_GAIN_RST, 16'hffff);
    rdev(`DUD_A_OFFS, `DUD_OFFS_RST, 16'hffff);
    rdev(`DUD_A_CHK, `DUD_CHK_RST, 16'hffff);
    rdev(`DUD_A_STAT, 16'h0001, 16'h0007);
    cmd(`DUD_A_RES, 16'h0001);
    rdev(`DUD_A_RES, 16'h0000, 16'h003f);
    k = 16'($urandom());
    cmd(`DUD_A_INPUT, k);
    cmd(`DUD_A_SLOAD, {12'h0, dev_addr ^ 4'h1});
    exp_dac.push_back(k);
    cmd(`DUD_A_SLOAD, {12'h0, dev_addr});
    cmd(`DUD_A_SETB, 16'h0001);
    k = 16'($urandom());
    cmd(`DUD_A_INPUT, k);
    exp_dac.push_back(k);
    cmd(`DUD_A_SLOAD, {12'h0, dev_addr ^ 4'h1});
    k = 16'($urandom());
    cmd(`DUD_A_INPUT, k);
    exp_dac.push_back(k);
    apb(1'b1, `DUD_H_CTRL, 32'h0);
    repeat (10) @(posedge pclk);
    for (int i = 0; i < 3; i++)
    begin
      k = 16'($urandom());
      exp_dac.push_back(k);
      cmd(`DUD_A_INPUT, k);
    end
    cmd(`DUD_A_GAIN, 16'h7fff);
    cmd(`DUD_A_OFFS, 16'h8010);
    cmd(`DUD_A_SLOAD, {12'h0, dev_addr});
    hrd(`DUD_H_STAT, 32'h1, 32'h1);
    apb(1'b1, `DUD_H_STAT, 32'h1);
    k = 16'($urandom());
    exp_dac.push_back(calc(k, 16'h7fff, 16'h8010));
    cmd(`DUD_A_INPUT, k);
    cmd(`DUD_A_GAIN, `DUD_GAIN_RST);
    cmd(`DUD_A_OFFS, `DUD_OFFS_RST);
    k = 16'h0;
    exp_dac.push_back(k);
    cmd(`DUD_A_INPUT, k);
    k = 16'($urandom());
    cmd(`DUD_A_WDC, 16'h0001);
    cmd(`DUD_A_CLEAR, k);
    exp_dac.push_back(k);
    pulse_wdog();
    rdev(`DUD_A_STAT, 16'h0004, 16'h0004);
    rdev(`DUD_A_RES, 16'h0002, 16'h0002);
    cmd(`DUD_A_INPUT, ~k);
    cmd(`DUD_A_RES, 16'h0002);
    rdev(`DUD_A_RES, 16'h0000, 16'h0002);
    exp_dac.push_back(k);
    cmd(`DUD_A_SLOAD, {12'h0, dev_addr});
    exp_dac.push_back(~k);
    cmd(`DUD_A_INPUT, ~k);
    cmd(`DUD_A_GAIN, 16'h1234);
    cmd(`DUD_A_WDC, 16'h0002);
    pulse_wdog();
    rdev(`DUD_A_RES, 16'h0001, 16'h003f);
    rdev(`DUD_A_GAIN, `DUD_GAIN_RST, 16'hffff);
    cmd(`DUD_A_RES, 16'h0001);
    apb(1'b1, `DUD_H_CTRL, 32'h2);
    repeat (6) @(posedge pclk);
    rdev(`DUD_A_RES, 16'h0001, 16'h003f);
    cmd(`DUD_A_KEY, `DUD_KEY_CAL);
    rdev(`DUD_A_RES, 16'h0000, 16'h0070);
    cmd(`DUD_A_CFG, 16'h0003);
    rdev(`DUD_A_RES, 16'h0000, 16'h0070);
    k = 16'($urandom());
    exp_dac.push_back(k);
    cmd(`DUD_A_INPUT, k);
    cmd(`DUD_A_RES, 16'h0001);
    cmd(`DUD_A_CHK, 16'h000f);
    latch_flip <= 1'b1;
    repeat (8) @(posedge pclk);
    rdev(`DUD_A_RES, 16'h0004, 16'h000c);
    rdev(`DUD_A_STAT, 16'h0001, 16'h0001);
    cmd(`DUD_A_RES, 16'h0004);
    rdev(`DUD_A_RES, 16'h0004, 16'h0004);
    latch_flip <= 1'b0;
    repeat (8) @(posedge pclk);
    cmd(`DUD_A_RES, 16'h0004);
    rdev(`DUD_A_RES, 16'h0000, 16'h0004);
    ana_fault <= 4'($urandom()) | 4'h1;
    repeat (6) @(posedge pclk);
    rdev(`DUD_A_STAT, 16'h0002, 16'h0002);
    ana_fault <= 4'h0;
    repeat (6) @(posedge pclk);
    cmd(`DUD_A_ANA, 16'h000f);
    rdev(`DUD_A_STAT, 16'h0000, 16'h0002);
    cmd(`DUD_A_RBSEL, {11'h0, `DUD_A_TICKS});
    apb(1'b0, `DUD_H_RDBK, 32'h0);
    t1 = rd;
    repeat (80) @(posedge pclk);
    apb(1'b0, `DUD_H_RDBK, 32'h0);
    `CHK((rd[15:0] - t1[15:0]) inside {[16'd9:16'd11]}, 1'b1)
    osc_halted <= 1'b1;
    repeat (6) @(posedge pclk);
    hrd(`DUD_H_RDBK, {8'h0, `DUD_HALT_WORD}, 32'h00ffffff);
    osc_halted <= 1'b0;
    repeat (6) @(posedge pclk);
    `CHK(exp_dac.size() + exp_rd.size(), 0)
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
